// ### src/gcs_pkg.sv
// Constants, field layouts and pin carrier types for the global config/status bank.
// Assumes a serial front end that presents decoded register accesses and UART events.
package gcs_pkg;

  // --------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------
  localparam logic [6:0] OFS_GLOBAL_STATUS_FLAGS  = 7'h01;
  localparam logic [6:0] OFS_WRITE_TRANSFER_COUNT = 7'h02;
  localparam logic [6:0] OFS_NODE_SETTINGS        = 7'h03;
  localparam logic [6:0] OFS_INPUT_PIN_STATE      = 7'h04;
  localparam logic [6:0] OFS_PIN_OUTPUT_CONTROL   = 7'h04;
  localparam logic [6:0] OFS_POSITION_MATCH_VALUE = 7'h05;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int FLAG_RESET_BIT        = 0;
  localparam int FLAG_DRIVER_ONE_BIT   = 1;
  localparam int FLAG_DRIVER_TWO_BIT   = 2;
  localparam int FLAG_UNDERVOLTAGE_BIT = 3;
  localparam int NODE_NUMBER_LSB       = 0;
  localparam int NODE_NUMBER_MSB       = 7;
  localparam int REPLY_DELAY_LSB       = 8;
  localparam int REPLY_DELAY_MSB       = 11;
  localparam int PIN_STATE_MSB         = 8;
  localparam int VERSION_LSB           = 24;
  localparam int VERSION_MSB           = 31;
  localparam int GP_LEVEL_LSB          = 0;
  localparam int GP_LEVEL_MSB          = 2;
  localparam int GP_DIR_LSB            = 8;
  localparam int GP_DIR_MSB            = 10;

  // --------------------------------------------------------------
  // Reset values and timing
  // --------------------------------------------------------------
  localparam logic [3:0]  RST_GLOBAL_STATUS_FLAGS  = 4'h1;
  localparam logic [7:0]  RST_WRITE_TRANSFER_COUNT = 8'h00;
  localparam logic [11:0] RST_NODE_SETTINGS        = 12'h000;
  localparam logic [31:0] RST_POSITION_MATCH_VALUE = 32'h00000000;
  localparam logic [10:0] RST_PIN_OUTPUT_CONTROL   = 11'h000;
  localparam logic [3:0]  REPLY_DELAY_MAX_CODE     = 4'hd;
  localparam int          BITS_PER_DELAY_UNIT      = 8;

  // --------------------------------------------------------------
  // Pin carrier, laid out as input_pin_state bits 8..0
  // --------------------------------------------------------------
  typedef struct packed {
    logic       wire_comparator_state;
    logic       drv_disable;
    logic       addr_step;
    logic       wire_neg;
    logic       wire_pos;
    logic [3:0] general_pin;
  } pins_t;

  typedef struct packed {
    logic driver_one_fault;
    logic driver_two_fault;
    logic pump_undervoltage;
  } faults_t;

endpackage : gcs_pkg

// ### src/global_config_status_regs.sv
// Global configuration and status register bank with pin control and position match.
// Assumes the serial front end decodes accesses into one-cycle read and write strobes.
`timescale 1ns/10ps

// Operation
// - Reset restores registers, sets reset flag
// - Driver one shutdown sets flag bit 1
// - Driver two shutdown sets flag bit 2
// - Fault flag clears only once condition gone
// - Undervoltage sets bit 3, disables drivers
// - Count increments per good UART write
// - Count unchanged by read, wraps 255 to 0
// - Count frozen in SPI operation
// - Node number bits 7..0, default zero
// - Address step pin adds one to node
// - Ring mode node zero stops forwarding
// - Input register shows eight pin levels
// - Wire lines are inputs in SPI mode
// - Bit 8 shows wire comparator result
// - Bits 31..24 hold fixed revision code
// - Output bits 0..2 set pin levels
// - Bits 8..10 set direction, pin 3 input
// - Pulse high while position equals match
// - Pulse only when output select enabled
// - Select routes pulse, interrupt; encoder unused
module global_config_status_regs
  import gcs_pkg::*;
#(
  parameter logic [7:0] VERSION_CODE = 8'h2a, // Arbitrary value
  parameter int         ADDR_W       = 7
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  input  wire logic              spi_mode,
  input  wire logic              uart_write_ok,
  input  wire logic              uart_read_req,
  input  wire logic              uart_bit_tick,
  input  wire logic              uart_drive,
  output logic                   uart_reply_go,
  output logic                   wire_oe_n,
  input  wire pins_t             pins_async,
  input  wire faults_t           faults,
  output logic                   driver_enable,
  input  wire logic [31:0]       current_position,
  input  wire logic              pulse_output_select,
  input  wire logic              ring_mode,
  input  wire logic              interrupt_req,
  output logic                   position_pulse_pin,
  output logic                   interrupt_pin,
  output logic                   encoder_one_enable,
  output logic      [2:0]        gp_out,
  output logic      [2:0]        gp_oe_n,
  output logic      [7:0]        node_number,
  output logic                   forward_enable
);

  if (ADDR_W != 7)
  begin : g_chk
    $error("global_config_status_regs ADDR_W must be 7");
  end

  // --------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------
  pins_t pins_s;
  logic [PIN_STATE_MSB:0] pins_vec;
  pin_sync #(
    .WIDTH ($bits(pins_t))
  ) pin_sync_inst (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .async_in (pins_async),
    .sync_out (pins_vec)
  );
  assign pins_s = pins_t'(pins_vec);

  // --------------------------------------------------------------
  // Access decode
  // --------------------------------------------------------------
  logic rd_flags;
  logic wr_node;
  logic wr_pins;
  logic wr_match;
  always_comb
  begin
    rd_flags = reg_rd && (reg_addr == OFS_GLOBAL_STATUS_FLAGS);
    wr_node  = 1'b0;
    wr_pins  = 1'b0;
    wr_match = 1'b0;
    if (reg_wr && reg_addr == OFS_NODE_SETTINGS)
    begin
      wr_node = 1'b1;
    end
    else if (reg_wr && reg_addr == OFS_PIN_OUTPUT_CONTROL)
    begin
      wr_pins = 1'b1;
    end
    else if (reg_wr && reg_addr == OFS_POSITION_MATCH_VALUE)
    begin
      wr_match = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Global status flags
  // --------------------------------------------------------------
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  always_comb
  begin
    flags_d = flags_q;
    if (rd_flags)
    begin
      flags_d = 4'h0;
    end
    flags_d[FLAG_DRIVER_ONE_BIT]   |= faults.driver_one_fault;
    flags_d[FLAG_DRIVER_TWO_BIT]   |= faults.driver_two_fault;
    flags_d[FLAG_UNDERVOLTAGE_BIT] |= faults.pump_undervoltage;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      flags_q <= RST_GLOBAL_STATUS_FLAGS;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign driver_enable = ~faults.pump_undervoltage;

  // --------------------------------------------------------------
  // Write transfer count
  // --------------------------------------------------------------
  logic [7:0] wcount_q;
  logic [7:0] wcount_d;
  always_comb
  begin
    wcount_d = wcount_q;
    if (uart_write_ok && !spi_mode)
    begin
      wcount_d = wcount_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wcount_q <= RST_WRITE_TRANSFER_COUNT;
    end
    else
    begin
      wcount_q <= wcount_d;
    end
  end

  // --------------------------------------------------------------
  // Node settings, pin output control, position match value
  // --------------------------------------------------------------
  logic [11:0] node_q;
  logic [11:0] node_d;
  logic [10:0] pinctl_q;
  logic [10:0] pinctl_d;
  logic [31:0] match_q;
  logic [31:0] match_d;
  always_comb
  begin
    node_d   = node_q;
    pinctl_d = pinctl_q;
    match_d  = match_q;
    if (wr_node)
    begin
      node_d = reg_wdata[REPLY_DELAY_MSB:NODE_NUMBER_LSB];
    end
    if (wr_pins)
    begin
      pinctl_d = 11'h000;
      pinctl_d[GP_LEVEL_MSB:GP_LEVEL_LSB] = reg_wdata[GP_LEVEL_MSB:GP_LEVEL_LSB];
      pinctl_d[GP_DIR_MSB:GP_DIR_LSB]     = reg_wdata[GP_DIR_MSB:GP_DIR_LSB];
    end
    if (wr_match)
    begin
      match_d = reg_wdata;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      node_q   <= RST_NODE_SETTINGS;
      pinctl_q <= RST_PIN_OUTPUT_CONTROL;
      match_q  <= RST_POSITION_MATCH_VALUE;
    end
    else
    begin
      node_q   <= node_d;
      pinctl_q <= pinctl_d;
      match_q  <= match_d;
    end
  end

  assign gp_out  = pinctl_q[GP_LEVEL_MSB:GP_LEVEL_LSB];
  assign gp_oe_n = ~pinctl_q[GP_DIR_MSB:GP_DIR_LSB];

  // --------------------------------------------------------------
  // Node addressing and forwarding
  // --------------------------------------------------------------
  logic [7:0] node_base;
  logic [7:0] node_eff_q;
  logic [7:0] node_eff_d;
  logic       fwd_q;
  logic       fwd_d;
  always_comb
  begin
    node_base  = node_q[NODE_NUMBER_MSB:NODE_NUMBER_LSB];
    node_eff_d = node_base + {7'h00, pins_s.addr_step};
    fwd_d      = !(ring_mode && node_base == 8'h00);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      node_eff_q <= 8'h00;
      fwd_q      <= 1'b1;
    end
    else
    begin
      node_eff_q <= node_eff_d;
      fwd_q      <= fwd_d;
    end
  end

  assign node_number    = node_eff_q;
  assign forward_enable = fwd_q;

  // --------------------------------------------------------------
  // Reply delay and wire line direction
  // --------------------------------------------------------------
  reply_delay_timer #(
    .CNT_W (7)
  ) reply_delay_timer_inst (
    .ref_clk     (ref_clk),
    .srst        (srst),
    .reply_delay (node_q[REPLY_DELAY_MSB:REPLY_DELAY_LSB]),
    .start       (uart_read_req && !spi_mode),
    .bit_tick    (uart_bit_tick),
    .reply_go    (uart_reply_go),
    .busy        ()
  );
  assign wire_oe_n = spi_mode | ~uart_drive;

  // --------------------------------------------------------------
  // Position match pulse and shared pin routing
  // --------------------------------------------------------------
  logic pulse_q;
  logic pulse_d;
  logic int_q;
  logic int_d;
  always_comb
  begin
    pulse_d = pulse_output_select && (current_position == match_q);
    int_d   = pulse_output_select && interrupt_req;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pulse_q <= 1'b0;
      int_q   <= 1'b0;
    end
    else
    begin
      pulse_q <= pulse_d;
      int_q   <= int_d;
    end
  end

  assign position_pulse_pin = pulse_q;
  assign interrupt_pin      = int_q;
  assign encoder_one_enable = ~pulse_output_select;

  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      rdata_d = 32'h00000000;
      if (reg_addr == OFS_GLOBAL_STATUS_FLAGS)
      begin
        rdata_d[3:0] = flags_q;
      end
      else if (reg_addr == OFS_WRITE_TRANSFER_COUNT)
      begin
        rdata_d[7:0] = wcount_q;
      end
      else if (reg_addr == OFS_INPUT_PIN_STATE)
      begin
        rdata_d[PIN_STATE_MSB:0]       = pins_vec;
        rdata_d[VERSION_MSB:VERSION_LSB] = VERSION_CODE;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule : global_config_status_regs

// ### src/pin_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence is promised.
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             ref_clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  if (WIDTH < 1)
  begin : g_chk
    $error("pin_sync WIDTH must be at least 1");
  end

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule : pin_sync

// ### src/reply_delay_timer.sv
// Counts UART bit times between a read request and the permitted reply start.
// Assumes bit_tick is a one-cycle pulse per bit time from the UART baud logic.
`timescale 1ns/10ps
module reply_delay_timer
  import gcs_pkg::*;
#(
  parameter int CNT_W = 7
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [3:0] reply_delay,
  input  wire logic       start,
  input  wire logic       bit_tick,
  output logic            reply_go,
  output logic            busy
);

  logic [CNT_W-1:0] remain_q;
  logic [CNT_W-1:0] remain_d;
  logic             busy_q;
  logic             busy_d;
  logic             go_q;
  logic             go_d;
  logic [3:0]       code_odd;
  logic [CNT_W-1:0] load_val;

  if (CNT_W < 7)
  begin : g_chk
    $error("reply_delay_timer CNT_W too small for longest delay");
  end

  // Codes pair up onto odd multiples of eight bit times; 14 and 15 clamp to 13
  always_comb
  begin
    code_odd = reply_delay | 4'h1;
    if (code_odd > REPLY_DELAY_MAX_CODE)
    begin
      code_odd = REPLY_DELAY_MAX_CODE;
    end
    load_val = CNT_W'(code_odd) * CNT_W'(BITS_PER_DELAY_UNIT);
  end

  always_comb
  begin
    remain_d = remain_q;
    busy_d   = busy_q;
    go_d     = 1'b0;
    if (start)
    begin
      remain_d = load_val;
      busy_d   = 1'b1;
    end
    else if (busy_q && bit_tick)
    begin
      if (remain_q == CNT_W'(1))
      begin
        busy_d = 1'b0;
        go_d   = 1'b1;
      end
      remain_d = remain_q - CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      remain_q <= '0;
      busy_q   <= 1'b0;
      go_q     <= 1'b0;
    end
    else
    begin
      remain_q <= remain_d;
      busy_q   <= busy_d;
      go_q     <= go_d;
    end
  end

  assign reply_go = go_q;
  assign busy     = busy_q;

endmodule : reply_delay_timer

// ### tb/gcs_checker_properties.sv
// Concurrent checks on the ports of the global config/status bank.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module gcs_checker
  import gcs_pkg::*;
#(
  parameter logic [7:0] VERSION_CODE = 8'h2a, // Arbitrary value
  parameter int         ADDR_W       = 7
) (
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic [31:0]       reg_rdata,
  input wire logic              spi_mode,
  input wire logic              wire_oe_n,
  input wire faults_t           faults,
  input wire logic              driver_enable,
  input wire logic [31:0]       current_position,
  input wire logic              pulse_output_select,
  input wire logic              position_pulse_pin,
  input wire logic              encoder_one_enable,
  input wire logic [2:0]        gp_out,
  input wire logic [2:0]        gp_oe_n,
  input wire logic              uart_reply_go
);
  // --------------------------------------------------------------
  // Shadow of the match value
  // --------------------------------------------------------------
  logic [31:0] match_q, match_d;
  always_comb
  begin
    match_d = match_q;
    if (srst)
      match_d = '0;
    else if (reg_wr && reg_addr == OFS_POSITION_MATCH_VALUE)
      match_d = reg_wdata;
  end
  always_ff @(posedge ref_clk)
    match_q <= match_d;

  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_rd_flags;
    reg_rd && reg_addr == OFS_GLOBAL_STATUS_FLAGS;
  endsequence
  sequence s_gp_wr;
    reg_wr && reg_addr == OFS_PIN_OUTPUT_CONTROL;
  endsequence
  property p_drv1_flag;
    (!$past(srst) && $past(faults.driver_one_fault) && faults.driver_one_fault) ##0 s_rd_flags
      |=> reg_rdata[1];
  endproperty
  property p_fault_hold;
    faults.driver_two_fault ##0 s_rd_flags ##1 !reg_rd ##1 s_rd_flags |=> reg_rdata[2];
  endproperty
  property p_uv_disable;
    driver_enable == !faults.pump_undervoltage;
  endproperty
  property p_spi_wire_in;
    spi_mode |-> wire_oe_n;
  endproperty
  property p_version;
    reg_rd && reg_addr == OFS_INPUT_PIN_STATE |=> reg_rdata[31:24] == VERSION_CODE;
  endproperty
  property p_pulse;
    !$past(srst) |->
      position_pulse_pin == $past(pulse_output_select && current_position == match_q);
  endproperty
  property p_enc;
    encoder_one_enable == !pulse_output_select;
  endproperty
  property p_gp;
    s_gp_wr ##1 !(reg_wr && reg_addr == OFS_PIN_OUTPUT_CONTROL)
      |=> gp_out == $past(reg_wdata[2:0], 2) && gp_oe_n == ~$past(reg_wdata[10:8], 2);
  endproperty
  property p_reply_pulse;
    uart_reply_go |=> !uart_reply_go;
  endproperty
  a_drv1_flag: assert property (p_drv1_flag)
    else $error("driver one flag not reported");
  a_fault_hold: assert property (p_fault_hold)
    else $error("driver two flag cleared while fault persists");
  a_uv_disable: assert property (p_uv_disable)
    else $error("driver enable does not follow undervoltage");
  a_spi_wire_in: assert property (p_spi_wire_in)
    else $error("wire lines driven in spi mode");
  a_version: assert property (p_version)
    else $error("revision field wrong");
  a_pulse: assert property (p_pulse)
    else $error("position pulse wrong");
  a_enc: assert property (p_enc)
    else $error("encoder enable wrong");
  a_gp: assert property (p_gp)
    else $error("pin control outputs wrong");
  a_reply_pulse: assert property (p_reply_pulse)
    else $error("reply start longer than one cycle");
endmodule : gcs_checker

bind global_config_status_regs gcs_checker #(.VERSION_CODE(VERSION_CODE), .ADDR_W(ADDR_W))
  gcs_checker_inst (.ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .spi_mode(spi_mode),
  .wire_oe_n(wire_oe_n), .faults(faults), .driver_enable(driver_enable),
  .current_position(current_position), .pulse_output_select(pulse_output_select),
  .position_pulse_pin(position_pulse_pin), .encoder_one_enable(encoder_one_enable),
  .gp_out(gp_out), .gp_oe_n(gp_oe_n), .uart_reply_go(uart_reply_go));

// ### tb/test_global_config_status_regs.sv
// Self-checking bench for the global config/status bank.
// Assumes the design package and the bit-time source model.
`timescale 1ns/10ps
module test_global_config_status_regs;
  import gcs_pkg::*;
  localparam logic [7:0] VER = 8'h5c; // Arbitrary value
  logic        ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [6:0]  reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, current_position = '0;
  logic        spi_mode = 1'b0, uart_write_ok = 1'b0, uart_read_req = 1'b0, uart_drive = 1'b0;
  logic        pulse_output_select = 1'b0, ring_mode = 1'b0, interrupt_req = 1'b0, run = 1'b0;
  logic        bit_tick, uart_reply_go, wire_oe_n, driver_enable, position_pulse_pin;
  logic        interrupt_pin, encoder_one_enable, forward_enable;
  logic [2:0]  gp_out, gp_oe_n;
  logic [7:0]  node_number;
  pins_t       pins = '0;
  faults_t     flt = '0;
  int          mismatches = 0, n_checks = 0;
  always #12.5 ref_clk = ~ref_clk;

  global_config_status_regs #(.VERSION_CODE(VER)) global_config_status_regs_inst (
    .ref_clk(ref_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .spi_mode(spi_mode),
    .uart_write_ok(uart_write_ok), .uart_read_req(uart_read_req), .uart_bit_tick(bit_tick),
    .uart_drive(uart_drive), .uart_reply_go(uart_reply_go), .wire_oe_n(wire_oe_n),
    .pins_async(pins), .faults(flt), .driver_enable(driver_enable),
    .current_position(current_position), .pulse_output_select(pulse_output_select),
    .ring_mode(ring_mode), .interrupt_req(interrupt_req),
    .position_pulse_pin(position_pulse_pin), .interrupt_pin(interrupt_pin),
    .encoder_one_enable(encoder_one_enable), .gp_out(gp_out), .gp_oe_n(gp_oe_n),
    .node_number(node_number), .forward_enable(forward_enable));
  uart_link_model #(.DIV(3)) uart_link_model_inst (
    .ref_clk(ref_clk), .srst(srst), .run(run), .bit_tick(bit_tick));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [6:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rdc

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    rdc(OFS_GLOBAL_STATUS_FLAGS, 32'h1);
    rdc(OFS_GLOBAL_STATUS_FLAGS, 32'h0);
    rdc(OFS_WRITE_TRANSFER_COUNT, 32'h0);
    rdc(7'h06, 32'h0);
  endtask : t_reset
  task automatic t_faults();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge ref_clk);
      flt <= 3'b100 >> i;
      cyc(2);
      chk(driver_enable, i != 2);
      rdc(OFS_GLOBAL_STATUS_FLAGS, 32'h2 << i);
      rdc(OFS_GLOBAL_STATUS_FLAGS, 32'h2 << i);
      @(posedge ref_clk);
      flt <= '0;
      rdc(OFS_GLOBAL_STATUS_FLAGS, 32'h2 << i);
      rdc(OFS_GLOBAL_STATUS_FLAGS, 32'h0);
    end
  endtask : t_faults
  task automatic okp(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      uart_write_ok <= 1'b1;
      @(posedge ref_clk);
      uart_write_ok <= 1'b0;
    end
  endtask : okp
  task automatic t_count();
    spi_mode <= 1'b1;
    okp(3);
    spi_mode <= 1'b0;
    rdc(OFS_WRITE_TRANSFER_COUNT, 32'h0);
    okp(258);
    rdc(OFS_WRITE_TRANSFER_COUNT, 32'h2);
    rdc(OFS_WRITE_TRANSFER_COUNT, 32'h2);
  endtask : t_count
  task automatic t_node();
    wr(OFS_NODE_SETTINGS, 32'h0000_00fd);
    cyc(3);
    chk(node_number, 8'hfd);
    @(posedge ref_clk);
    pins.addr_step <= 1'b1;
    cyc(4);
    chk(node_number, 8'hfe);
    pins.addr_step <= 1'b0;
    ring_mode <= 1'b1;
    wr(OFS_NODE_SETTINGS, 32'h0);
    cyc(4);
    chk(forward_enable, 1'b0);
    @(posedge ref_clk);
    ring_mode <= 1'b0;
    cyc(2);
    chk(forward_enable, 1'b1);
  endtask : t_node
  task automatic t_delay();
    logic [3:0] codes [4];
    int n;
    int k;
    codes = '{4'h0, 4'h2, 4'hd, 4'hf};
    foreach (codes[c])
    begin
      wr(OFS_NODE_SETTINGS, {20'h0, codes[c], 8'h00});
      @(posedge ref_clk);
      uart_read_req <= 1'b1;
      run <= 1'b1;
      @(posedge ref_clk);
      uart_read_req <= 1'b0;
      n = 0;
      for (k = 0; k < 1000 && uart_reply_go !== 1'b1; k++)
      begin
        #1;
        if (uart_reply_go !== 1'b1)
        begin
          n += (bit_tick === 1'b1);
          @(posedge ref_clk);
        end
      end
      if (k == 1000)
      begin
        mismatches++;
        $display("[ERR] %0t reply start timeout", $time);
        final_report();
      end
      chk(n, 8 * ((codes[c] > 4'hd) ? 13 : (codes[c] | 4'h1)));
      @(posedge ref_clk);
      run <= 1'b0;
    end
  endtask : t_delay
  task automatic t_pins();
    @(posedge ref_clk);
    pins <= 9'h1a5;
    spi_mode <= 1'b1;
    uart_drive <= 1'b1;
    cyc(4);
    chk(wire_oe_n, 1'b1);
    rdc(OFS_INPUT_PIN_STATE, {VER, 15'h0, 9'h1a5});
    spi_mode <= 1'b0;
    cyc(1);
    chk(wire_oe_n, 1'b0);
    uart_drive <= 1'b0;
  endtask : t_pins
  task automatic t_gpio();
    wr(OFS_PIN_OUTPUT_CONTROL, 32'h0000_0605);
    cyc(3);
    chk({gp_out, gp_oe_n}, 6'b101_001);
    wr(OFS_PIN_OUTPUT_CONTROL, 32'h0000_0ff8);
    cyc(3);
    chk({gp_out, gp_oe_n}, 6'b000_000);
  endtask : t_gpio
  task automatic t_pulse();
    wr(OFS_POSITION_MATCH_VALUE, 32'h1234_5678);
    current_position <= 32'h1234_5678;
    pulse_output_select <= 1'b1;
    interrupt_req <= 1'b1;
    cyc(2);
    chk({position_pulse_pin, interrupt_pin, encoder_one_enable}, 3'b110);
    current_position <= 32'h1234_5679;
    cyc(2);
    chk(position_pulse_pin, 1'b0);
    current_position <= 32'h1234_5678;
    pulse_output_select <= 1'b0;
    cyc(2);
    chk({position_pulse_pin, encoder_one_enable}, 2'b01);
  endtask : t_pulse
  task automatic t_rst_mid();
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    cyc(3);
    chk({node_number, gp_oe_n}, 11'h007);
    rdc(OFS_GLOBAL_STATUS_FLAGS, 32'h1);
  endtask : t_rst_mid

  initial
  begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    t_reset();
    $display("test reset done");
    t_faults();
    $display("test faults done");
    t_count();
    $display("test count done");
    t_node();
    $display("test node done");
    t_delay();
    $display("test delay done");
    t_pins();
    $display("test pins done");
    t_gpio();
    $display("test gpio done");
    t_pulse();
    $display("test pulse done");
    t_rst_mid();
    $display("test midrun reset done");
    final_report();
  end
endmodule : test_global_config_status_regs

// ### tb/uart_link_model.sv
// Far-side bit-time source: one tick every DIV cycles while run is high.
// Assumes the same clock as the bank; idle means no ticks at all.
`timescale 1ns/10ps
module uart_link_model #(
  parameter int DIV = 3
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      bit_tick
);
  logic [7:0] cnt_q, cnt_d;
  logic       tick_q, tick_d;
  always_comb
  begin
    cnt_d  = (run && cnt_q != 8'(DIV - 1)) ? cnt_q + 8'h01 : 8'h00;
    tick_d = run && cnt_q == 8'(DIV - 1);
  end
  always_ff @(posedge ref_clk)
  begin
    cnt_q  <= srst ? 8'h00 : cnt_d;
    tick_q <= srst ? 1'b0 : tick_d;
  end
  assign bit_tick = tick_q;
endmodule : uart_link_model
